// ### logic/nfc_pkg.sv
// Constants and types shared by the fast-charge sequencer.
package nfc_pkg;
   // Register byte addresses on the bus.
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_DIV      = 8'h04;
   localparam logic [7:0]  ADDR_STATUS   = 8'h08;
   localparam logic [7:0]  ADDR_PEAK     = 8'h0C;
   localparam logic [7:0]  ADDR_TICKS    = 8'h10;
   // Field positions.
   localparam int          CTRL_RESTART  = 0;
   localparam int          ST_STATE_LSB  = 0;
   localparam int          ST_CAUSE_LSB  = 4;
   localparam int          ST_OT_BIT     = 8;
   localparam int          ST_INIT_BIT   = 9;
   // Base tick: one battery sample interval at the nominal timer setting.
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          VBAT_SAMPLE_S = 4;
   localparam int          TEMP_SAMPLE_S = 8;
   localparam int          SLOPE_SPAN_S  = 56;
   localparam int          SAFETY_MIN    = 80;
   localparam logic [31:0] TICK_CYCLES   = 32'(VBAT_SAMPLE_S * CLK_HZ);
   localparam int          TEST_SHIFT    = 9;
   // Counts in base ticks; history depth in temperature samples, trickle counter width in bits.
   localparam logic [10:0] SAFETY_TICKS  = 11'(SAFETY_MIN * 60 / VBAT_SAMPLE_S);
   localparam logic [10:0] INIT_TICKS    = 11'(SAFETY_MIN * 60 / VBAT_SAMPLE_S / 80);
   localparam logic [10:0] FLAT_TICKS    = 11'(SAFETY_MIN * 60 / VBAT_SAMPLE_S * 6 / 100);
   localparam int          TEMP_EVERY    = TEMP_SAMPLE_S / VBAT_SAMPLE_S;
   localparam int          SLOPE_DEPTH   = SLOPE_SPAN_S / TEMP_SAMPLE_S;
   localparam int          TRICKLE_W     = 7;
   // Sense codes: 10-bit conversions with full scale at supply (5 V).
   localparam int          CODE_W        = 10;
   localparam logic [9:0]  VBAT_LO_INIT  = 10'h021;
   localparam logic [9:0]  VBAT_LO_RUN   = 10'h08D;
   localparam logic [9:0]  VBAT_HI       = 10'h229;
   localparam logic [9:0]  TEMP_HOT      = 10'h129;
   localparam logic [9:0]  TEMP_COLD     = 10'h2E1;
   localparam logic [9:0]  ADJ_OFF       = 10'h3C3;
   localparam logic [19:0] NEG_DV_DEN    = 20'h00190;
   localparam logic [19:0] NEG_DV_NUM    = 20'h0018F;
   localparam logic [14:0] SLOPE_GAIN    = 15'h001E;
   localparam logic [1:0]  SETTLE_CYC    = 2'h3;

   typedef enum logic [1:0] {ST_QUAL, ST_FAST, ST_TRICKLE, ST_SUSPEND} nfc_state_t;
   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_NEG_DV, CAUSE_FLAT, CAUSE_SLOPE,
      CAUSE_TIMEOUT, CAUSE_MAX_V, CAUSE_MAX_T
   } nfc_cause_t;
endpackage

// ### logic/nfc_sequencer.sv
// Fast-charge sequencer with AHB-Lite register access.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Power-on reset clears every timer and state.
// - Battery outside window suspends, holding logic reset; in fast charge, high after the initial period ends charge.
// - Temperature outside window suspends before fast charge; in fast charge cold suspends, hot ends charge.
// - Low temperature code means hot; high, cold.
// - Fast charge starts both timers together.
// - Initial period masks four voltage/slope terminations.
// - Initial timer is one eightieth of safety.
// - Battery sampled every base tick, scaling.
// - Sample 0.25% below peak ends fast charge.
// - Peak held for 6% of safety ends.
// - Temperature rise (temperature code drop) over 56 s ends charge.
// - Temperature sampled every second base tick.
// - AC mode disables falling and flat terminations.
// - High slope-adjust level disables slope termination.
// - Safety timer expiry ends fast charge.
// - Maximum voltage or temperature ends charge.
// - Any termination moves to trickle charge.
// - Trickle releases current one slot in 128.
// - After initial period lower battery limit rises.
// - Output inhibits at start, faults; off fast.
// - Over-temperature latches suspend; under-temperature does not.
// - Test mode shortens the base tick, and so all tick-counted timing, by 512; the settle cycles are not scaled.
module nfc_sequencer #(
   parameter logic [31:0] TICK_CYCLES_DEF = nfc_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // Sense inputs from the converters and mode comparators.
   input  wire logic [9:0]  battery_sense_input_i,
   input  wire logic [9:0]  temp_sense_input_i,
   input  wire logic [9:0]  slope_adjust_input_i,
   input  wire logic        mode_ac_i,
   input  wire logic        mode_test_i,
   // Open-drain charge control pin.
   output logic             charge_control_output_o,
   output logic             charge_control_output_oe_o,
   // AHB-Lite slave.
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hwdata_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o
);
   localparam int SW = 32;

   logic [SW-1:0]          sync1_reg;
   logic [SW-1:0]          sync2_reg;
   logic [9:0]             vbat;
   logic [9:0]             temp;
   logic [9:0]             slope_adjust_input;
   logic                   mode_ac;
   logic                   mode_test;
   nfc_pkg::nfc_state_t    state_reg;
   nfc_pkg::nfc_state_t    state_next;
   nfc_pkg::nfc_cause_t    cause_reg;
   nfc_pkg::nfc_cause_t    cause_next;
   logic [31:0]            div_reg;
   logic [31:0]            div_eff;
   logic [31:0]            pre_cnt_reg;
   logic                   tick;
   logic [10:0]            tick_cnt_reg;
   logic [10:0]            flat_cnt_reg;
   logic [9:0]             peak_reg;
   logic [9:0]             hist_reg [nfc_pkg::SLOPE_DEPTH];
   logic [2:0]             hist_cnt_reg;
   logic [6:0]             trickle_cnt_reg;
   logic [1:0]             settle_reg;
   logic                   ot_latch_reg;
   logic                   restart_reg;
   logic                   init_done;
   logic                   temp_hot;
   logic                   temp_cold;
   logic                   vbat_bad;
   logic                   term_neg;
   logic                   term_flat;
   logic                   term_slope;
   logic                   term_time;
   logic                   term_maxv;
   logic                   term_maxt;
   logic                   term_any;
   logic                   enter_fast;
   logic                   charge_control_output_on_reg;
   logic [14:0]            temp_drop;
   logic                   dp_write_reg;
   logic [7:0]             dp_addr_reg;
   logic [31:0]            rdata_next;
   logic                   addr_phase;

   function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo,
                                     input logic [9:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // Sense codes are sampled at ticks in fast charge, but qualification and suspend exit read them on any cycle,
   // so the one-cycle skew between bits of a changing code through the two flops can be acted on there.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {mode_test_i, mode_ac_i, slope_adjust_input_i,
                       temp_sense_input_i, battery_sense_input_i};
         sync2_reg <= sync1_reg;
      end
   end
   assign vbat      = sync2_reg[9:0];
   assign temp      = sync2_reg[19:10];
   assign slope_adjust_input       = sync2_reg[29:20];
   assign mode_ac   = sync2_reg[30];
   assign mode_test = sync2_reg[31];

   // Prescaler producing the base tick.
   always_comb begin
      div_eff = mode_test ? (div_reg >> nfc_pkg::TEST_SHIFT) : div_reg;
      if (div_eff == 32'h0000_0000) begin
         div_eff = 32'h0000_0001;
      end
   end
   assign tick = (pre_cnt_reg >= div_eff - 32'h0000_0001);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pre_cnt_reg <= '0;
      end else if (tick || state_reg == nfc_pkg::ST_SUSPEND) begin
         pre_cnt_reg <= '0;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
      end
   end

   // Decoding of the sense codes.
   // Outside fast charge the battery is judged against the pre-qualification limit.
   assign init_done = state_reg == nfc_pkg::ST_FAST
                      && tick_cnt_reg >= nfc_pkg::INIT_TICKS;
   assign temp_hot  = temp < nfc_pkg::TEMP_HOT;
   assign temp_cold = temp > nfc_pkg::TEMP_COLD;
   assign vbat_bad  = !in_range(vbat, init_done ? nfc_pkg::VBAT_LO_RUN
                                : nfc_pkg::VBAT_LO_INIT, 10'h3FF);
   assign temp_drop = (hist_reg[nfc_pkg::SLOPE_DEPTH-1] > temp)
                      ? 15'(hist_reg[nfc_pkg::SLOPE_DEPTH-1] - temp) : 15'h0000;

   // Terminations, evaluated on ticks in fast charge.
   always_comb begin
      term_time  = tick_cnt_reg + 11'h001 >= nfc_pkg::SAFETY_TICKS;
      term_maxt  = temp_hot;
      term_maxv  = init_done && vbat > nfc_pkg::VBAT_HI;
      term_neg   = init_done && !mode_ac
                   && 20'(vbat) * nfc_pkg::NEG_DV_DEN <= 20'(peak_reg) * nfc_pkg::NEG_DV_NUM;
      term_flat  = init_done && !mode_ac
                   && flat_cnt_reg + 11'h001 >= nfc_pkg::FLAT_TICKS;
      term_slope = init_done && slope_adjust_input <= nfc_pkg::ADJ_OFF
                   && hist_cnt_reg == 3'(nfc_pkg::SLOPE_DEPTH)
                   && tick_cnt_reg[0]
                   && temp_drop * nfc_pkg::SLOPE_GAIN > 15'(slope_adjust_input);
      term_any   = term_time | term_maxt | term_maxv | term_neg | term_flat | term_slope;
   end

   // Charge state sequence.
   always_comb begin
      state_next = state_reg;
      cause_next = cause_reg;
      case (state_reg)
         nfc_pkg::ST_QUAL: begin
            if (settle_reg == nfc_pkg::SETTLE_CYC) begin
               if (vbat_bad || vbat > nfc_pkg::VBAT_HI || temp_hot || temp_cold) begin
                  state_next = nfc_pkg::ST_SUSPEND;
               end else begin
                  state_next = nfc_pkg::ST_FAST;
                  cause_next = nfc_pkg::CAUSE_NONE;
               end
            end
         end
         nfc_pkg::ST_FAST: begin
            if (tick && term_any) begin
               state_next = nfc_pkg::ST_TRICKLE;
               if (term_maxt) cause_next = nfc_pkg::CAUSE_MAX_T;
               else if (term_maxv) cause_next = nfc_pkg::CAUSE_MAX_V;
               else if (term_time) cause_next = nfc_pkg::CAUSE_TIMEOUT;
               else if (term_neg) cause_next = nfc_pkg::CAUSE_NEG_DV;
               else if (term_flat) cause_next = nfc_pkg::CAUSE_FLAT;
               else cause_next = nfc_pkg::CAUSE_SLOPE;
            end else if (tick && (vbat_bad || temp_cold
                                  || (!init_done && vbat > nfc_pkg::VBAT_HI))) begin
               state_next = nfc_pkg::ST_SUSPEND;
            end
         end
         nfc_pkg::ST_TRICKLE: begin
            state_next = nfc_pkg::ST_TRICKLE;
         end
         nfc_pkg::ST_SUSPEND: begin
            if (!ot_latch_reg && !vbat_bad && vbat <= nfc_pkg::VBAT_HI
                && !temp_hot && !temp_cold) begin
               state_next = nfc_pkg::ST_QUAL;
            end
         end
         default: begin
            state_next = nfc_pkg::ST_QUAL;
         end
      endcase
      if (restart_reg) begin
         state_next = nfc_pkg::ST_QUAL;
      end
   end
   assign enter_fast = state_reg != nfc_pkg::ST_FAST && state_next == nfc_pkg::ST_FAST;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= nfc_pkg::ST_QUAL;
         cause_reg <= nfc_pkg::CAUSE_NONE;
      end else begin
         state_reg <= state_next;
         cause_reg <= cause_next;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         settle_reg <= '0;
      end else if (state_reg != nfc_pkg::ST_QUAL) begin
         settle_reg <= '0;
      end else if (settle_reg != nfc_pkg::SETTLE_CYC) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   // Over-temperature latch; only reset or a restart clears it.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ot_latch_reg <= 1'b0;
      end else if (state_next == nfc_pkg::ST_SUSPEND && temp_hot) begin
         ot_latch_reg <= 1'b1;
      end else if (restart_reg) begin
         ot_latch_reg <= 1'b0;
      end
   end

   // Initial and safety timers share one tick counter.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_cnt_reg <= '0;
      end else if (enter_fast) begin
         tick_cnt_reg <= '0;
      end else if (state_reg == nfc_pkg::ST_FAST && tick) begin
         tick_cnt_reg <= tick_cnt_reg + 11'h001;
      end
   end

   // Peak voltage and the flat-voltage duration.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         peak_reg     <= '0;
         flat_cnt_reg <= '0;
      end else if (enter_fast) begin
         peak_reg     <= '0;
         flat_cnt_reg <= '0;
      end else if (state_reg == nfc_pkg::ST_FAST && tick) begin
         if (vbat > peak_reg) begin
            peak_reg     <= vbat;
            flat_cnt_reg <= '0;
         end else begin
            flat_cnt_reg <= flat_cnt_reg + 11'h001;
         end
      end
   end

   // Temperature history; the oldest entry is one slope span back.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hist_cnt_reg <= '0;
         for (int i = 0; i < nfc_pkg::SLOPE_DEPTH; i++) hist_reg[i] <= '0;
      end else if (enter_fast) begin
         hist_cnt_reg <= '0;
      end else if (state_reg == nfc_pkg::ST_FAST && tick && tick_cnt_reg[0]) begin
         hist_reg[0] <= temp;
         for (int i = 1; i < nfc_pkg::SLOPE_DEPTH; i++) hist_reg[i] <= hist_reg[i-1];
         if (hist_cnt_reg != 3'(nfc_pkg::SLOPE_DEPTH)) begin
            hist_cnt_reg <= hist_cnt_reg + 3'h1;
         end
      end
   end

   // Trickle slot counter and the pin drive.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trickle_cnt_reg <= '0;
      end else if (state_reg != nfc_pkg::ST_TRICKLE) begin
         trickle_cnt_reg <= '0;
      end else if (tick) begin
         trickle_cnt_reg <= trickle_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         charge_control_output_on_reg <= 1'b1;
      end else begin
         case (state_reg)
            nfc_pkg::ST_FAST:    charge_control_output_on_reg <= 1'b0;
            nfc_pkg::ST_TRICKLE: charge_control_output_on_reg <= trickle_cnt_reg != 7'h00;
            default:             charge_control_output_on_reg <= 1'b1;
         endcase
      end
   end
   // The pin only ever pulls low; the level itself stays at zero.
   assign charge_control_output_oe_o = charge_control_output_on_reg;
   assign charge_control_output_o    = 1'b0;

   // Bus slave: zero wait states, read data registered in the address phase.
   assign addr_phase = hsel_i && htrans_i[1] && hready_i;
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (haddr_i[7:0])
         nfc_pkg::ADDR_DIV:    rdata_next = div_reg;
         nfc_pkg::ADDR_STATUS: begin
            rdata_next[nfc_pkg::ST_STATE_LSB +: 2] = state_reg;
            rdata_next[nfc_pkg::ST_CAUSE_LSB +: 3] = cause_reg;
            rdata_next[nfc_pkg::ST_OT_BIT]         = ot_latch_reg;
            rdata_next[nfc_pkg::ST_INIT_BIT]       = init_done;
         end
         nfc_pkg::ADDR_PEAK:   rdata_next = {22'h000000, peak_reg};
         nfc_pkg::ADDR_TICKS:  rdata_next = {21'h000000, tick_cnt_reg};
         default:              rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dp_write_reg <= 1'b0;
         dp_addr_reg  <= '0;
         hrdata_o     <= '0;
      end else begin
         dp_write_reg <= addr_phase && hwrite_i && hsize_i == 3'h2;
         dp_addr_reg  <= haddr_i[7:0];
         if (addr_phase && !hwrite_i) begin
            hrdata_o <= rdata_next;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_reg     <= TICK_CYCLES_DEF;
         restart_reg <= 1'b0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         restart_reg <= dp_write_reg && dp_addr_reg == nfc_pkg::ADDR_CTRL
                        && hwdata_i[nfc_pkg::CTRL_RESTART];
         if (dp_write_reg && dp_addr_reg == nfc_pkg::ADDR_DIV) begin
            div_reg <= hwdata_i;
         end
      end
   end

   // Checks.
   sequence s_enter_fast;
      enter_fast ##1 (state_reg == nfc_pkg::ST_FAST);
   endsequence
   property p_fast_clears;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_enter_fast |-> peak_reg == 10'h000 && flat_cnt_reg == 11'h000 && tick_cnt_reg == 11'h000;
   endproperty
   a_fast_clears: assert property (p_fast_clears) else $error("counters not cleared");
   property p_fast_releases;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_enter_fast ##1 (state_reg == nfc_pkg::ST_FAST) |-> !charge_control_output_oe_o;
   endproperty
   a_fast_releases: assert property (p_fast_releases) else $error("pin held in fast");
   property p_suspend_inhibits;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_reg == nfc_pkg::ST_SUSPEND) [*2] |-> charge_control_output_oe_o;
   endproperty
   a_suspend_inhibits: assert property (p_suspend_inhibits) else $error("suspend not inhibiting");
   property p_init_mask;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_reg == nfc_pkg::ST_FAST && tick_cnt_reg < nfc_pkg::INIT_TICKS)
      |-> !(term_neg || term_flat || term_slope || term_maxv);
   endproperty
   a_init_mask: assert property (p_init_mask) else $error("termination not masked");
   property p_ac_mode;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      mode_ac |-> !term_neg && !term_flat;
   endproperty
   a_ac_mode: assert property (p_ac_mode) else $error("ac mode termination");
   property p_timeout;
      @(posedge sys_clk_i) disable iff (sys_rst_i || restart_reg)
      (state_reg == nfc_pkg::ST_FAST && tick && tick_cnt_reg == nfc_pkg::SAFETY_TICKS - 11'h001)
      |=> state_reg == nfc_pkg::ST_TRICKLE ##0 cause_reg != nfc_pkg::CAUSE_NONE;
   endproperty
   a_timeout: assert property (p_timeout) else $error("safety timeout missed");
   property p_ot_latch;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      ot_latch_reg && !restart_reg |=> ot_latch_reg && state_reg != nfc_pkg::ST_QUAL;
   endproperty
   a_ot_latch: assert property (p_ot_latch) else $error("over-temperature latch lost");
   property p_trickle_duty;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_reg == nfc_pkg::ST_TRICKLE)
      |=> charge_control_output_oe_o == ($past(trickle_cnt_reg) != 7'h00);
   endproperty
   a_trickle_duty: assert property (p_trickle_duty) else $error("trickle duty wrong");
   property p_hot_ends;
      @(posedge sys_clk_i) disable iff (sys_rst_i || restart_reg)
      (state_reg == nfc_pkg::ST_FAST && tick && temp_hot)
      |=> state_reg == nfc_pkg::ST_TRICKLE && cause_reg == nfc_pkg::CAUSE_MAX_T;
   endproperty
   a_hot_ends: assert property (p_hot_ends) else $error("max temperature missed");
endmodule
`default_nettype wire

// ### dv/nfc_partner.sv
// Far-side model: battery divider, thermistor, slope-adjust source and power stage.
`timescale 1ns/1ps
`default_nettype none
module nfc_partner (
   // Clock and levels asked for by the bench.
   input  wire logic       clk_i,
   input  wire logic [9:0] vbat_set_i,
   input  wire logic [9:0] temp_set_i,
   input  wire logic [9:0] adj_set_i,
   // Pin from the sequencer.
   input  wire logic       ctrl_oe_i,
   // Sense codes and charging current.
   output logic [9:0]      vbat_o,
   output logic [9:0]      temp_o,
   output logic [9:0]      adj_o,
   output logic            current_on_o
);
   // Levels move just after an edge, as a real divider would settle between samples.
   always_ff @(posedge clk_i) begin
      vbat_o <= vbat_set_i;
      temp_o <= temp_set_i;
      adj_o  <= adj_set_i;
   end
   // A pulled-on pin shunts the stage, so current flows only while released.
   assign current_on_o = !ctrl_oe_i;
endmodule
`default_nettype wire

// ### dv/nfc_sequencer_tb.sv
// Self-checking bench for the fast-charge sequencer.
`timescale 1ns/1ps
`default_nettype none
module nfc_sequencer_tb;
   logic        clk, rst, hsel, hwrite, ac, oe, hrdy, hresp, cur, mtest, od;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [9:0]  vset, tset, aset, vb, ts, aj;
   int          mismatches, checks_done, n;
   nfc_partner PART (.clk_i(clk), .vbat_set_i(vset), .temp_set_i(tset), .adj_set_i(aset),
      .ctrl_oe_i(oe), .vbat_o(vb), .temp_o(ts), .adj_o(aj), .current_on_o(cur));
   nfc_sequencer #(.TICK_CYCLES_DEF(32'h14)) DUT (.sys_clk_i(clk), .sys_rst_i(rst),
      .battery_sense_input_i(vb), .temp_sense_input_i(ts), .slope_adjust_input_i(aj),
      .mode_ac_i(ac), .mode_test_i(mtest), .charge_control_output_o(od),
      .charge_control_output_oe_o(oe), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata),
      .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Waits out hready under a bound; the slave is zero-wait but nothing is assumed.
   task automatic hwait();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (hrdy !== 1'b1) begin
         chk("hready", 32'h1, 32'h0);
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hwait();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hwait();
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Polls the status word until the masked field matches; 15000 reads is the limit.
   task automatic wfor(input logic [31:0] m, input logic [31:0] v);
      for (int i = 0; i < 15000; i++) begin
         bus(1'b0, nfc_pkg::ADDR_STATUS, 32'h0);
         if ((q & m) === v) return;
      end
      chk("status wait", v, q & m);
      finish_test();
   endtask
   task automatic restart();
      bus(1'b1, nfc_pkg::ADDR_CTRL, 32'h1);
   endtask
   initial begin
      {hsel, hwrite, ac, mtest, htrans, haddr, hwdata} = '0;
      vset = 10'h12C;
      tset = 10'h1F4;
      aset = 10'h3FF;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      chk("oe in reset", 32'h1, {31'h0, oe});
      chk("pin level", 32'h0, {31'h0, od});
      rst <= 1'b0;
      bus(1'b0, nfc_pkg::ADDR_DIV, 32'h0);
      chk("div reset", 32'h14, q);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, q);
      wfor(32'h3, 32'h1);
      @(posedge clk);
      chk("oe fast", 32'h0, {31'h0, oe});
      vset <= 10'h258;
      wfor(32'h3, 32'h3);
      chk("oe fault", 32'h1, {31'h0, oe});
      vset <= 10'h12C;
      wfor(32'h3, 32'h1);
      wfor(32'h200, 32'h200);
      vset <= 10'h258;
      wfor(32'h3, 32'h2);
      chk("cause maxv", 32'h5, {29'h0, q[6:4]});
      n = 0;
      repeat (128 * 20) begin
         @(posedge clk);
         n += (cur === 1'b1);
      end
      chk("trickle low cycles", 32'h14, n);
      // Falling-voltage end: 398 against a peak of 400 is just past the quarter percent.
      vset <= 10'h190;
      restart();
      wfor(32'h203, 32'h201);
      // The peak must hold 400 before the drop, or the drop only sets a lower peak.
      wfor(32'h200, 32'h200);
      bus(1'b0, nfc_pkg::ADDR_PEAK, 32'h0);
      chk("peak after restart", 32'h190, q);
      vset <= 10'h18E;
      wfor(32'h3, 32'h2);
      chk("cause negdv", 32'h1, {29'h0, q[6:4]});
      // AC mode drops the falling and flat voltage ends, so only the safety timer can finish.
      ac <= 1'b1;
      vset <= 10'h190;
      restart();
      wfor(32'h203, 32'h201);
      wfor(32'h200, 32'h200);
      vset <= 10'h18E;
      wfor(32'h3, 32'h2);
      chk("cause timeout", 32'h4, {29'h0, q[6:4]});
      ac <= 1'b0;
      tset <= 10'h064;
      restart();
      wfor(32'h3, 32'h3);
      chk("hot latch", 32'h1, {31'h0, q[8]});
      tset <= 10'h1F4;
      repeat (100) @(posedge clk);
      bus(1'b0, nfc_pkg::ADDR_STATUS, 32'h0);
      chk("hot stays", 32'h3, {30'h0, q[1:0]});
      restart();
      wfor(32'h3, 32'h1);
      tset <= 10'h320;
      wfor(32'h3, 32'h3);
      chk("cold latch", 32'h0, {31'h0, q[8]});
      tset <= 10'h1F4;
      wfor(32'h3, 32'h1);
      // Test mode turns a base tick of 0x2800 cycles into 20; unscaled, the waits time out.
      mtest <= 1'b1;
      aset <= 10'h01E;
      bus(1'b1, nfc_pkg::ADDR_DIV, 32'h2800);
      restart();
      wfor(32'h203, 32'h201);
      wfor(32'h200, 32'h200);
      bus(1'b0, nfc_pkg::ADDR_TICKS, 32'h0);
      chk("ticks at init end", 32'hF, q);
      tset <= 10'h1E0;
      wfor(32'h3, 32'h2);
      chk("cause slope", 32'h3, {29'h0, q[6:4]});
      restart();
      wfor(32'h3, 32'h1);
      tset <= 10'h064;
      wfor(32'h3, 32'h2);
      chk("cause maxt", 32'h6, {29'h0, q[6:4]});
      finish_test();
   end
endmodule
`default_nettype wire
